//--- hw/speech_core.sv
// Sequencer and datapath of the speech processor core.
// Assumes a ROM that answers rom_addr combinationally and same-clock control inputs.
`timescale 1ns/1ps
`default_nettype none
module speech_core
    import speech_core_pkg::*;
#(
    parameter int PC_W = PC_W_LARGE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    output logic [PC_W-1:0] rom_addr,
    input wire logic [7:0] rom_data,
    input wire logic irq_req,
    output logic irq_ack,
    input wire logic speech_active,
    input wire logic [7:0] synth_addr,
    input wire logic [7:0] synth_wdata,
    input wire logic synth_we,
    output logic [7:0] synth_rdata,
    output logic synth_grant,
    output logic instr_fetch,
    output logic [PC_W-1:0] pc,
    output logic [ALU_W-1:0] acc,
    output logic sign_mode,
    output logic status_flag
);
    stack_if #(.W(PC_W), .DW(DEPTH_W)) stk ();
    ram_if ram ();

    // The stack and RAM sit behind interfaces so each bundle of controls travels together.
    return_stack #(.DEPTH(STACK_DEPTH), .W(PC_W), .DW(DEPTH_W)) u_stack (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .port(stk)
    );

    core_ram u_ram (
        .clk(clk),
        .ce(ce),
        .cpu(ram),
        .speech_active(speech_active),
        .synth_addr(synth_addr),
        .synth_wdata(synth_wdata),
        .synth_we(synth_we),
        .synth_rdata(synth_rdata),
        .synth_grant(synth_grant)
    );

    // Opcode decoders shared by the sequencer and the assertions.
    function automatic logic two_byte(input logic [7:0] o);
        return (o[7:5] == 3'b001) || o[7];
    endfunction

    function automatic logic rom_op(input logic [7:0] o);
        return (o == OP_UNPACK) || (o == OP_LOOKUP) || (o[7:3] == OP_GET_BASE[7:3]);
    endfunction

    function automatic logic stack_op(input logic [7:0] o);
        return rom_op(o) || (o == OP_SUB_RET) || (o == OP_INT_RET) || (o == OP_POP) || (o[7:6] == 2'b11);
    endfunction

    logic [4:0] phase_q, phase_d;
    logic [7:0] op_q, op_d, opnd_q, opnd_d, ps_q, ps_d;
    logic [PC_W-1:0] pc_q, pc_d, sar_q, sar_d, rom_addr_q, rom_addr_d, pc_next, far_target;
    logic [ALU_W-1:0] a_q, a_d, shadow_q, shadow_d, ram_val;
    logic [3:0] cnt_q, cnt_d, rem_q, rem_d;
    seq_state_t st_q, st_d;
    logic sign_q, sign_d, status_q, status_d, busy_q, busy_d, ack_q, ack_d, irq_take;

    assign pc_next = pc_q + (two_byte(op_q) ? PC_W'(2) : PC_W'(1));
    assign far_target = PC_W'({op_q[5:0], opnd_q});
    // Bytes from RAM enter the ten-bit path through the mode latch.
    assign ram_val = widen(ram.rdata, sign_q);

    // One instruction takes 32 phases: opcode at phase 0, operand at phase 1,
    // ROM work from phase 3 and every other architectural update at phase 31.
    always_comb begin
        phase_d = (phase_q == PH_EXEC) ? PH_FETCH : phase_q + 5'h01;
        op_d = op_q;
        opnd_d = opnd_q;
        ps_d = ps_q;
        pc_d = pc_q;
        sar_d = sar_q;
        rom_addr_d = rom_addr_q;
        a_d = a_q;
        shadow_d = shadow_q;
        cnt_d = cnt_q;
        rem_d = rem_q;
        st_d = st_q;
        sign_d = sign_q;
        status_d = status_q;
        busy_d = busy_q;
        ack_d = 1'b0;
        irq_take = 1'b0;
        stk.push = 1'b0;
        stk.pop = 1'b0;
        stk.push_data = pc_q;
        ram.addr = opnd_q;
        ram.wdata = a_q[7:0];
        ram.we = 1'b0;
        if (phase_q == PH_FETCH) begin
            op_d = rom_data;
            rom_addr_d = pc_q + PC_W'(1);
        end
        if (phase_q == PH_OPERAND) begin
            opnd_d = rom_data;
        end
        // ROM accesses borrow one stack level while they run and give it back at phase 31.
        case (st_q)
            ST_IDLE: begin
                if (phase_q == PH_WORK && rom_op(op_q)) begin
                    stk.push = 1'b1;
                    if (op_q == OP_LOOKUP) begin
                        rom_addr_d = PC_W'(a_q);
                        st_d = ST_READ;
                    end else if (op_q == OP_UNPACK) begin
                        cnt_d = 4'h0;
                        rom_addr_d = sar_q;
                        st_d = ST_READ;
                    end else begin
                        a_d = ACC_RESET;
                        rem_d = 4'({1'b0, op_q[2:0]} + 4'h1);
                        if (cnt_q == 4'h0) begin
                            rom_addr_d = sar_q;
                            st_d = ST_READ;
                        end else begin
                            st_d = ST_SHIFT;
                        end
                    end
                end
            end
            ST_READ: begin
                if (op_q == OP_LOOKUP) begin
                    a_d = widen(rom_data, sign_q);
                    st_d = ST_DONE;
                end else begin
                    ps_d = rom_data;
                    cnt_d = PS_BITS;
                    sar_d = sar_q + PC_W'(1);
                    st_d = (op_q == OP_UNPACK) ? ST_DONE : ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (rem_q == 4'h0) begin
                    st_d = ST_DONE;
                end else if (cnt_q == 4'h0) begin
                    rom_addr_d = sar_q;
                    st_d = ST_READ;
                end else begin
                    a_d = {a_q[8:0], ps_q[7]};
                    ps_d = {ps_q[6:0], 1'b0};
                    cnt_d = cnt_q - 4'h1;
                    rem_d = rem_q - 4'h1;
                end
            end
            ST_DONE: begin
            end
            default: st_d = ST_IDLE;
        endcase
        if (phase_q == PH_EXEC) begin
            st_d = ST_IDLE;
            pc_d = pc_next;
            casez (op_q)
                8'b01??????: pc_d = {pc_q[PC_W-1:6], op_q[5:0]};
                8'b10??????: pc_d = far_target;
                8'b11??????: begin
                    stk.push = 1'b1;
                    stk.push_data = pc_next;
                    pc_d = far_target;
                end
                OP_SUB_RET: begin
                    stk.pop = 1'b1;
                    pc_d = stk.top;
                end
                OP_INT_RET: begin
                    stk.pop = 1'b1;
                    pc_d = stk.top;
                    a_d = shadow_q;
                    busy_d = 1'b0;
                end
                OP_POP: stk.pop = 1'b1;
                OP_UNPACK, OP_LOOKUP, 8'b00010???: stk.pop = 1'b1;
                OP_SIGN_MODE: sign_d = 1'b1;
                OP_ZERO_MODE: sign_d = 1'b0;
                OP_SAR_LO: sar_d = {sar_q[PC_W-1:8], a_q[7:0]};
                OP_SAR_HI: sar_d = {a_q[PC_W-9:0], sar_q[7:0]};
                OP_LDM: a_d = ram_val;
                OP_STM: ram.we = 1'b1;
                OP_ADD: a_d = a_q + ram_val;
                OP_AND: a_d = {a_q[9:8], a_q[7:0] & ram.rdata};
                OP_CMP: status_d = (a_q[7:0] == ram.rdata);
                OP_LDI: a_d = widen(opnd_q, sign_q);
                default: pc_d = pc_next;
            endcase
            // Interrupts are taken only between instructions that leave the stack alone,
            // so the saved return address never races a push or pop of the same cycle.
            if (irq_req && !busy_q && !stack_op(op_q)) begin
                irq_take = 1'b1;
                stk.push = 1'b1;
                stk.push_data = pc_d;
                shadow_d = a_d;
                pc_d = PC_W'(IRQ_VECTOR);
                busy_d = 1'b1;
                ack_d = 1'b1;
            end
            rom_addr_d = pc_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= PH_FETCH;
            op_q <= OP_NOP;
            opnd_q <= 8'h00;
            ps_q <= 8'h00;
            pc_q <= PC_W'(RESET_PC);
            sar_q <= PC_W'(RESET_PC);
            rom_addr_q <= PC_W'(RESET_PC);
            a_q <= ACC_RESET;
            shadow_q <= ACC_RESET;
            cnt_q <= 4'h0;
            rem_q <= 4'h0;
            st_q <= ST_IDLE;
            sign_q <= 1'b0;
            status_q <= 1'b0;
            busy_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (ce) begin
            phase_q <= phase_d;
            op_q <= op_d;
            opnd_q <= opnd_d;
            ps_q <= ps_d;
            pc_q <= pc_d;
            sar_q <= sar_d;
            rom_addr_q <= rom_addr_d;
            a_q <= a_d;
            shadow_q <= shadow_d;
            cnt_q <= cnt_d;
            rem_q <= rem_d;
            st_q <= st_d;
            sign_q <= sign_d;
            status_q <= status_d;
            busy_q <= busy_d;
            ack_q <= ack_d;
        end
    end

    assign rom_addr = rom_addr_q;
    assign instr_fetch = (phase_q == PH_FETCH);
    assign pc = pc_q;
    assign acc = a_q;
    assign sign_mode = sign_q;
    assign status_flag = status_q;
    assign irq_ack = ack_q;

    // Counts cycles between fetches so that the fetch spacing can be checked.
    logic [5:0] gap_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_q <= 6'h00;
        end else if (ce) begin
            gap_q <= instr_fetch ? 6'h01 : gap_q + 6'h01;
        end
    end

    // Assertions rest while reset is held or the clock enable is low.
    default clocking @(posedge clk); endclocking
    default disable iff (rst || !ce);
    fetch_period_a: assert property (instr_fetch && $past(ce) && $past(gap_q) != 6'h00 |-> gap_q == 6'h20)
        else $error("Instruction fetch spacing is not 32 cycles.");
    pc_advance_a: assert property (phase_q == PH_EXEC && !stack_op(op_q) && op_q[7:6] != 2'b01 && op_q[7:6] != 2'b10
        && !irq_take |=> pc_q == $past(pc_next))
        else $error("Program counter did not advance sequentially.");
    call_push_a: assert property (phase_q == PH_EXEC && op_q[7:6] == 2'b11 |=> stk.top == $past(pc_next)
        && pc_q == $past(far_target))
        else $error("Call did not push the return address.");
    ret_load_a: assert property (phase_q == PH_EXEC && op_q == OP_SUB_RET |=> pc_q == $past(stk.top))
        else $error("Return did not load the top entry.");
    rom_balance_a: assert property (phase_q == PH_WORK && rom_op(op_q) && stk.depth < DEPTH_W'(STACK_DEPTH)
        |=> stk.depth == $past(stk.depth) + 1'b1)
        else $error("ROM access did not take a stack level.");
    lookup_range_a: assert property (st_q == ST_READ && op_q == OP_LOOKUP |-> rom_addr_q <= PC_W'(TABLE_LIMIT))
        else $error("Table lookup reached beyond its range.");
    sign_fill_a: assert property (st_q == ST_READ && op_q == OP_LOOKUP |=>
        a_q[9:8] == ($past(sign_q) ? {2{$past(rom_data[7])}} : 2'b00))
        else $error("Upper accumulator bits filled wrongly.");
    shadow_restore_a: assert property (phase_q == PH_EXEC && op_q == OP_INT_RET |=> a_q == $past(shadow_q))
        else $error("Interrupt return did not restore the accumulator.");
    sar_inc_a: assert property (st_q == ST_READ && op_q != OP_LOOKUP |=> sar_q == $past(sar_q) + PC_W'(1))
        else $error("Speech pointer did not increment after reload.");
    call_seen_c: cover property (phase_q == PH_EXEC && op_q[7:6] == 2'b11);
    get_reload_c: cover property (st_q == ST_SHIFT && cnt_q == 4'h0 && rem_q != 4'h0);
    irq_return_c: cover property (irq_take ##[1:300] (phase_q == PH_EXEC && op_q == OP_INT_RET));
    irq_vector_a: assert property (irq_take |=> pc_q == PC_W'(IRQ_VECTOR) && irq_ack && stk.top == $past(stk.push_data))
        else $error("Accepted interrupt did not vector and save its return address.");
    and_upper_a: assert property (phase_q == PH_EXEC && op_q == OP_AND |=> a_q[9:8] == $past(a_q[9:8]))
        else $error("Bitwise operation changed the upper accumulator bits.");
    lookup_read_c: cover property (st_q == ST_READ && op_q == OP_LOOKUP);
    unpack_read_c: cover property (st_q == ST_READ && op_q == OP_UNPACK);
endmodule
`default_nettype wire

//--- shared/speech_core_pkg.sv
// Constants, types and helper functions shared by the speech core datapath.
// Assumes a single 250 MHz clock that is the chip oscillator.
// Behaviour
// - One instruction is fetched from program ROM every 32 oscillator cycles.
// - Program counter is 13 bits for small ROM, 14 bits for large ROM.
// - After each instruction the counter advances unless the instruction loads it.
// - Far jump, near jump, call and both returns replace the program counter.
// - Five-entry return stack; calls and accepted interrupts push the program counter.
// - Both return instructions load the counter from the top entry and remove it.
// - Unpack-init, bit-fetch and table lookup push then pop the counter while running.
// - A pop instruction discards the top stack entry without touching the counter.
// - Bit fetch moves one to eight ROM bits into the accumulator; unpack-init loads a ROM byte and sets count to eight.
// - Table lookup loads one ROM byte, reaching only addresses 0 to 3FF.
// - RAM addresses 0-7F are bytes, 80-8F are nibbles.
// - During speech the synthesizer uses RAM 0-18 and 80-8F; otherwise the processor owns RAM.
// - The arithmetic path is ten bits wide.
// - Bytes enter right-justified; top two bits zero or copies of bit 7 by mode latch.
// - Logic and compare operations use only the low eight bits.
// - Accumulator is saved to a shadow on interrupt and restored by interrupt return.
// - Sign-extend op sets the mode latch, zero-fill op clears it.
// - Each unpack-init or bit-fetch reload reads ROM at the pointer, then increments it.
package speech_core_pkg;
    localparam int CYCLES_PER_INSTR = 32;
    localparam int PC_W_SMALL = 13;
    localparam int PC_W_LARGE = 14;
    localparam int STACK_DEPTH = 5;
    localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);
    localparam int ALU_W = 10;
    localparam int RAM_BYTES = 128;
    localparam int RAM_NIBBLES = 16;
    localparam logic [4:0] PH_FETCH = 5'h00;
    localparam logic [4:0] PH_OPERAND = 5'h01;
    localparam logic [4:0] PH_WORK = 5'h03;
    localparam logic [4:0] PH_EXEC = 5'(CYCLES_PER_INSTR - 1);
    localparam logic [13:0] RESET_PC = 14'h0000;
    localparam logic [13:0] IRQ_VECTOR = 14'h0010;
    localparam logic [13:0] TABLE_LIMIT = 14'h03FF;
    localparam logic [9:0] ACC_RESET = 10'h000;
    localparam logic [3:0] PS_BITS = 4'h8;
    localparam logic [7:0] RAM_BYTE_LAST = 8'h7F;
    localparam logic [7:0] RAM_NIB_FIRST = 8'h80;
    localparam logic [7:0] RAM_NIB_LAST = 8'h8F;
    localparam logic [7:0] SYNTH_BYTE_LAST = 8'h18;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_SUB_RET = 8'h01;
    localparam logic [7:0] OP_INT_RET = 8'h02;
    localparam logic [7:0] OP_POP = 8'h03;
    localparam logic [7:0] OP_UNPACK = 8'h04;
    localparam logic [7:0] OP_LOOKUP = 8'h05;
    localparam logic [7:0] OP_SIGN_MODE = 8'h06;
    localparam logic [7:0] OP_ZERO_MODE = 8'h07;
    localparam logic [7:0] OP_SAR_LO = 8'h08;
    localparam logic [7:0] OP_SAR_HI = 8'h09;
    localparam logic [7:0] OP_GET_BASE = 8'h10;
    localparam logic [7:0] OP_LDM = 8'h20;
    localparam logic [7:0] OP_STM = 8'h21;
    localparam logic [7:0] OP_ADD = 8'h22;
    localparam logic [7:0] OP_AND = 8'h23;
    localparam logic [7:0] OP_CMP = 8'h24;
    localparam logic [7:0] OP_LDI = 8'h25;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_SHIFT = 4'h4,
        ST_DONE = 4'h8
    } seq_state_t;

    function automatic logic [9:0] widen(input logic [7:0] b, input logic sign);
        return {(sign ? {2{b[7]}} : 2'b00), b};
    endfunction

    function automatic logic synth_window(input logic [7:0] a);
        return (a <= SYNTH_BYTE_LAST) || ((a >= RAM_NIB_FIRST) && (a <= RAM_NIB_LAST));
    endfunction
endpackage

//--- shared/core_links_if.sv
// Interfaces between the core and its return stack and RAM.
// Both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface stack_if #(parameter int W = 14, parameter int DW = 3);
    logic push;
    logic pop;
    logic [W-1:0] push_data;
    logic [W-1:0] top;
    logic [DW-1:0] depth;
    modport core (output push, output pop, output push_data, input top, input depth);
    modport store (input push, input pop, input push_data, output top, output depth);
endinterface

interface ram_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

//--- hw/return_stack.sv
// Program counter return stack with oldest-entry discard on overflow.
// Push and pop come from the core; both in one cycle leave it unchanged.
`timescale 1ns/1ps
`default_nettype none
module return_stack
    import speech_core_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int W = PC_W_LARGE,
    parameter int DW = DEPTH_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    stack_if.store port
);
    logic [W-1:0] ent_q [DEPTH];
    logic [W-1:0] ent_d [DEPTH];
    logic [DW-1:0] depth_q, depth_d;

    always_comb begin
        ent_d = ent_q;
        depth_d = depth_q;
        if (port.push && !port.pop) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                ent_d[i] = ent_q[i - 1];
            end
            ent_d[0] = port.push_data;
            if (depth_q != DW'(DEPTH)) begin
                depth_d = depth_q + 1'b1;
            end
        end else if (port.pop && !port.push) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                ent_d[i] = ent_q[i + 1];
            end
            ent_d[DEPTH - 1] = '0;
            if (depth_q != '0) begin
                depth_d = depth_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_q[i] <= '0;
            end
            depth_q <= '0;
        end else if (ce) begin
            ent_q <= ent_d;
            depth_q <= depth_d;
        end
    end

    assign port.top = ent_q[0];
    assign port.depth = depth_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst || !ce);
    full_drop_a: assert property (port.push && !port.pop && depth_q == DW'(DEPTH) |=>
        depth_q == DW'(DEPTH) && ent_q[0] == $past(port.push_data) && ent_q[DEPTH - 1] == $past(ent_q[DEPTH - 2]))
        else $error("Full stack push did not drop the oldest entry.");
    pop_top_a: assert property (port.pop && !port.push && depth_q > 1 |=>
        ent_q[0] == $past(ent_q[1]) && depth_q == $past(depth_q) - 1'b1)
        else $error("Pop did not expose the next entry.");
endmodule
`default_nettype wire

//--- hw/core_ram.sv
// Byte and nibble RAM shared between the core and the synthesizer.
// The synthesizer port is honoured only inside its window while speech runs.
`timescale 1ns/1ps
`default_nettype none
module core_ram
    import speech_core_pkg::*;
(
    input wire logic clk,
    input wire logic ce,
    ram_if.mem cpu,
    input wire logic speech_active,
    input wire logic [7:0] synth_addr,
    input wire logic [7:0] synth_wdata,
    input wire logic synth_we,
    output logic [7:0] synth_rdata,
    output logic synth_grant
);
    logic [7:0] byte_mem [RAM_BYTES];
    logic [3:0] nib_mem [RAM_NIBBLES];

    // Nibbles read back zero-padded; unmapped addresses read zero.
    function automatic logic [7:0] read_loc(input logic [7:0] a);
        if (a <= RAM_BYTE_LAST) begin
            return byte_mem[a[6:0]];
        end
        if (a <= RAM_NIB_LAST) begin
            return {4'h0, nib_mem[a[3:0]]};
        end
        return 8'h00;
    endfunction

    assign synth_grant = speech_active && synth_window(synth_addr);
    // A process, not an assign, so a write to the location being read shows up at once.
    always_comb begin
        cpu.rdata = read_loc(cpu.addr);
    end

    // The core write wins when both ports hit the same location.
    always_ff @(posedge clk) begin
        if (ce) begin
            if (cpu.we && cpu.addr <= RAM_BYTE_LAST) begin
                byte_mem[cpu.addr[6:0]] <= cpu.wdata;
            end else if (cpu.we && cpu.addr >= RAM_NIB_FIRST && cpu.addr <= RAM_NIB_LAST) begin
                nib_mem[cpu.addr[3:0]] <= cpu.wdata[3:0];
            end
            if (synth_grant && synth_we && !(cpu.we && cpu.addr == synth_addr)) begin
                if (synth_addr <= RAM_BYTE_LAST) begin
                    byte_mem[synth_addr[6:0]] <= synth_wdata;
                end else begin
                    nib_mem[synth_addr[3:0]] <= synth_wdata[3:0];
                end
            end
            synth_rdata <= synth_grant ? read_loc(synth_addr) : 8'h00;
        end
    end

    default clocking @(posedge clk); endclocking
    nibble_upper_a: assert property (cpu.addr >= RAM_NIB_FIRST && cpu.addr <= RAM_NIB_LAST |-> cpu.rdata[7:4] == 4'h0)
        else $error("Nibble location returned upper bits.");
    synth_refuse_a: assert property (!speech_active || (synth_addr > SYNTH_BYTE_LAST && synth_addr < RAM_NIB_FIRST)
        |-> !synth_grant)
        else $error("Synthesizer granted outside its window.");
endmodule
`default_nettype wire

//--- dv/test_speech_core.sv
// Self-checking bench for the speech core: it plays a small program ROM.
// Assumes the core's default 14-bit counter; the bench also acts as the synthesizer.
`timescale 1ns/1ps
`default_nettype none
`define check(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module test_speech_core;
    import speech_core_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic irq_req = 1'b0;
    logic speech_active = 1'b0;
    logic synth_we = 1'b0;
    logic [7:0] synth_addr = 8'h00;
    logic [7:0] synth_wdata = 8'h00;
    logic [7:0] rom_data, synth_rdata;
    logic [13:0] rom_addr, pc;
    logic [9:0] acc;
    logic irq_ack, synth_grant, instr_fetch, sign_mode, status_flag;
    logic [7:0] rom [0:255];
    int fails = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    // Addresses above the program image read as all ones.
    assign rom_data = (rom_addr < 14'h0100) ? rom[rom_addr[7:0]] : 8'hFF;
    speech_core speech_core_i (.clk(clk), .rst(rst), .ce(ce), .rom_addr(rom_addr), .rom_data(rom_data),
        .irq_req(irq_req), .irq_ack(irq_ack), .speech_active(speech_active), .synth_addr(synth_addr),
        .synth_wdata(synth_wdata), .synth_we(synth_we), .synth_rdata(synth_rdata), .synth_grant(synth_grant),
        .instr_fetch(instr_fetch), .pc(pc), .acc(acc), .sign_mode(sign_mode), .status_flag(status_flag));
    task automatic end_of_test;
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic put(input logic [7:0] a, input logic [511:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            rom[a + 8'(i)] = v[8 * (n - 1 - i) +: 8];
        end
    endtask
    // Waits for the fetch of the instruction at the given address.
    task automatic run_to(input logic [13:0] target);
        int k;
        k = 0;
        @(negedge clk);
        while (!(instr_fetch === 1'b1 && pc === target)) begin
            k++;
            if (k > 400) begin
                fails++;
                $display("unexpected at %0t: no fetch at %h", $time, target);
                end_of_test();
            end
            @(negedge clk);
        end
        comparisons++;
    endtask
    task automatic t_reset;
        `check(pc, 14'h0000)
        `check(acc, 10'h000)
        `check(sign_mode, 1'b0)
        `check(instr_fetch, 1'b1)
    endtask
    task automatic t_sequence;
        int n;
        run_to(14'h0040);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (instr_fetch !== 1'b1 && n < 40);
        `check(n, 32)
        `check(pc, 14'h0042)
        `check(rom_addr, 14'h0042)
        `check(acc, 10'h085)
    endtask
    task automatic t_alu;
        run_to(14'h0043);
        `check(sign_mode, 1'b1)
        run_to(14'h0045);
        `check(acc, 10'h385)
        run_to(14'h0049);
        `check(acc, 10'h005)
        run_to(14'h004A);
        `check(sign_mode, 1'b0)
        run_to(14'h0050);
        `check(acc, 10'h1FE)
        run_to(14'h0055);
        `check(status_flag, 1'b1)
    endtask
    task automatic t_stack_rom;
        run_to(14'h0080);
        run_to(14'h0058);
        run_to(14'h005B);
        `check(acc, 10'h0A5)
        run_to(14'h0063);
        `check(acc, 10'h002)
        run_to(14'h0064);
        `check(acc, 10'h0D1)
        run_to(14'h0091);
        run_to(14'h0072);
        `check(acc, 10'h02A)
    endtask
    task automatic t_irq;
        int k;
        k = 0;
        irq_req = 1'b1;
        while (irq_ack !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        irq_req = 1'b0;
        `check(irq_ack, 1'b1)
        `check(pc, IRQ_VECTOR)
        run_to(14'h0012);
        `check(acc, 10'h011)
        run_to(14'h0014);
        `check(acc, 10'h001)
        run_to(14'h0073);
        `check(acc, 10'h02A)
        run_to(14'h0073);
    endtask
    task automatic t_hold;
        int n;
        ce = 1'b0;
        repeat (40) @(negedge clk);
        `check(instr_fetch, 1'b1)
        `check(pc, 14'h0073)
        ce = 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (instr_fetch !== 1'b1 && n < 40);
        `check(n, 32)
    endtask
    task automatic t_synth;
        speech_active = 1'b1;
        synth_addr = 8'h05;
        synth_wdata = 8'hAA;
        synth_we = 1'b1;
        @(negedge clk);
        `check(synth_grant, 1'b1)
        synth_we = 1'b0;
        @(negedge clk);
        `check(synth_rdata, 8'hAA)
        synth_addr = 8'h8A;
        @(negedge clk);
        `check(synth_rdata, 8'h05)
        synth_addr = 8'h20;
        @(negedge clk);
        `check(synth_grant, 1'b0)
        `check(synth_rdata, 8'h00)
        speech_active = 1'b0;
        synth_addr = 8'h05;
        @(negedge clk);
        `check(synth_grant, 1'b0)
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            rom[i] = 8'h00;
        end
        put(8'h00, 512'(16'h8040), 2);
        put(8'h10, 512'(40'h2511_238A_02), 5);
        put(8'h30, 512'(16'hB46C), 2);
        rom[8'h37] = 8'hA5;
        put(8'h40, 512'({192'h2585_0625_8521_8A20_8A07_25FF_2110_2210_0625_FF24_1007_C080,
            112'h2537_0525_0009_2530_0804_1117_C090}), 38);
        put(8'h70, 512'(32'h252A_0073), 4);
        rom[8'h80] = 8'h01;
        put(8'h90, 512'(24'h038070), 3);
        repeat (12) @(negedge clk);
        t_reset();
        rst = 1'b0;
        t_sequence();
        t_alu();
        t_stack_rom();
        t_irq();
        t_hold();
        t_synth();
        end_of_test();
    end
endmodule
`default_nettype wire
